// ===== testbench.sv
// Self-checking bench for the timer with dead time, over classic Wishbone.
// Assumes TYPE_ONE timer, first of its pair, and the far-side event model.
`timescale 1ns/1ps
module testbench
    import tpw_pkg::*;
;
    // ----------------------------------------
    // Signals and instances
    // ----------------------------------------
    logic ref_clk, rst_n, cyc, stb, we, ack, extIn, evtOvf, evtErr, dmaReq, irqOut;
    logic [7:0] adr, evtCmd, evtIn, portVal, pinOut;
    logic [3:0] sel, waveOut, evtCc;
    logic [31:0] datW, datR, rdVal;
    logic prevWave;
    logic [15:0] casCnt;
    logic [1:0] wmode;
    logic watch;
    logic [6:0] seen;
    int fails, comparisons, highs, rises;

    tpw_timer #(.TYPE_ONE(1'b1), .PAIR_IDX(1'b0)) u_tpw_timer (
        .ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW), .wb_dat_o(datR), .wb_ack_o(ack),
        .evtIn(evtIn), .extIn(extIn), .cascadeCnt(casCnt), .portVal(portVal),
        .pinOut(pinOut), .waveOut(waveOut), .evtOvf(evtOvf), .evtErr(evtErr),
        .evtCc(evtCc), .dmaReq(dmaReq), .irqOut(irqOut));

    tpw_evt_model u_tpw_evt_model (
        .ref_clk(ref_clk), .rst_n(rst_n), .evtCmd(evtCmd), .evtIn(evtIn),
        .extIn(extIn), .portVal(portVal));

    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        datW <= d;
        sel <= 4'hF;
        // Only the watchdog ends a wait for the answer
        do
        begin
            @(posedge ref_clk);
        end while (ack !== 1'b1);
        rdVal = datR;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb_xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a);
        wb_xfer(1'b0, a, 32'h0);
    endtask

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            fails++;
        end
    endtask

    task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            $display("MISMATCH t=%0t pins got=%h exp=%h", $time, got, exp);
            fails++;
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // Sticky record of output pulses while a test watches
    always @(posedge ref_clk)
    begin
        if (watch)
            seen <= seen | {evtOvf, dmaReq, evtErr, evtCc};
        else
            seen <= 7'h0;
    end

    task automatic report_and_stop;
        if (fails == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ----------------------------------------
    // Clock, reset and watchdog
    // ----------------------------------------
    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // Whole run is well under a thousand cycles; this bound only catches a hang
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        report_and_stop;
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial
    begin
        rst_n = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'h0;
        datW = 32'h0;
        evtCmd = 8'h00;
        casCnt = 16'h5A3C;
        watch = 1'b0;
        fails = 0;
        comparisons = 0;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        // First edge after release loads the pins, second one shows them
        cycles(2);
        chk_pin(pinOut, portVal);
        rd(OFF_CTRL);
        chk_reg(rdVal, CTRL_RST);
        rd(OFF_PER);
        chk_reg(rdVal, {16'h0, PER_RST});
        rd(8'h40);
        chk_reg(rdVal, 32'h0);
        wr(OFF_DT, 32'hFFFF_A512);
        rd(OFF_DT);
        chk_reg(rdVal, 32'h0000_A512);
        wr(OFF_CNT, 32'hABCD_1234);
        rd(OFF_CNT);
        chk_reg(rdVal, 32'h0000_1234);
        // Dead time with idle wave: low side off, high side on
        wr(OFF_DT, 32'h0202);
        wr(OFF_PAT, 32'h0003);
        wr(OFF_FLT, 32'h0001);
        wr(OFF_CTRL, 32'h1 << CT_AWU);
        cycles(10);
        chk_pin(pinOut, {portVal[7:2], 2'b10});
        // Single-cycle fault event must latch until acknowledged
        evtCmd <= 8'h01;
        cycles(1);
        evtCmd <= 8'h00;
        cycles(4);
        chk_pin(pinOut, {portVal[7:2], 2'b00});
        rd(OFF_FLT);
        chk_reg(rdVal, 32'h0101);
        cycles(20);
        chk_pin(pinOut, {portVal[7:2], 2'b00});
        wr(OFF_FLT, 32'h0101);
        cycles(10);
        chk_pin(pinOut, {portVal[7:2], 2'b10});
        rd(OFF_FLT);
        chk_reg(rdVal, 32'h0001);
        wr(OFF_FLT, 32'h0000);
        // Pattern mode: channel A wave on pins 3:0, pin 0 inverted
        wr(OFF_PAT, 32'h010F);
        wr(OFF_CTRL, (32'h1 << CT_AWU) | (32'h1 << CT_PAT));
        cycles(5);
        chk_pin(pinOut, {portVal[7:4], 4'b0001});
        // Capture: short glitch rejected, both edges, second one errors
        wr(OFF_CTRL, 32'h0);
        wr(OFF_FLAG, 32'hFF);
        wr(OFF_CTRL, 32'h1 | (32'h1 << CT_CAPE) | (32'h1 << CT_BOTH) | (32'h1 << CT_CAS));
        watch <= 1'b1;
        evtCmd <= 8'h01;
        cycles(2);
        evtCmd <= 8'h00;
        cycles(10);
        rd(OFF_FLAG);
        chk_reg(rdVal, 32'h0);
        evtCmd <= 8'h01;
        cycles(12);
        rd(OFF_FLAG);
        chk_reg(rdVal, 32'h1 << FL_CC);
        chk_reg({31'h0, irqOut}, 32'h1);
        rd(OFF_CAP32);
        chk_reg(rdVal, 32'h5A3C);
        evtCmd <= 8'h00;
        cycles(12);
        rd(OFF_FLAG);
        chk_reg(rdVal, (32'h1 << FL_CC) | (32'h1 << FL_ERR));
        chk_reg({25'h0, seen}, 32'h31);
        watch <= 1'b0;
        // Period 8 ticks, compare 3: single slope without and with extender,
        // then dual slope and frequency on the extender
        for (int m = 0; m < 4; m++)
        begin
            wmode = (m == 3) ? WM_FREQ : (m == 2) ? WM_DS : WM_SS;
            wr(OFF_CTRL, 32'h0);
            wr(OFF_FLAG, 32'hFF);
            wr(OFF_CNT, 32'h0);
            wr(OFF_PER, 32'h7);
            wr(OFF_CC0, 32'h3);
            wr(OFF_CC0 + CC_STEP, 32'h8);
            wr(OFF_CTRL, 32'h1 | ({30'h0, wmode} << CT_WM) | (32'(m > 0) << CT_HRE));
            cycles(40);
            watch <= 1'b1;
            highs = 0;
            rises = 0;
            @(posedge ref_clk);
            prevWave = waveOut[0];
            // Dual slope repeats every 14 ticks, so it takes four whole periods
            repeat ((m == 2) ? 56 : 64)
            begin
                @(posedge ref_clk);
                if (waveOut[0] === 1'b1 && prevWave === 1'b0)
                    rises++;
                if (waveOut[0] === 1'b1)
                    highs++;
                prevWave = waveOut[0];
            end
            chk_reg(32'(highs), (m == 2) ? 32'h14 : (m == 3) ? 32'h20 : 32'h18);
            chk_reg(32'(rises), (m == 0) ? 32'h2 : (m == 2) ? 32'h4 : 32'h8);
            chk_reg({29'h0, waveOut[3:1]}, (m == 3) ? 32'h0 : 32'h1);
            chk_reg({30'h0, seen[6:5]}, 32'h3);
            watch <= 1'b0;
            rd(OFF_FLAG);
            chk_reg(rdVal & 32'h1, 32'h1);
        end
        // Event counting: channel 0 rises count, event 1 high counts down
        wr(OFF_CTRL, 32'h0);
        wr(OFF_CNT, 32'h0);
        wr(OFF_CTRL, 32'h1 | ({30'h0, SRC_EVT} << CT_SRC) | (32'h1 << CT_DIRE)
            | (32'h1 << CT_DSEL));
        repeat (5)
        begin
            evtCmd <= 8'h01;
            cycles(1);
            evtCmd <= 8'h00;
            cycles(1);
        end
        cycles(2);
        rd(OFF_CNT);
        chk_reg(rdVal, 32'h5);
        evtCmd <= 8'h02;
        repeat (2)
        begin
            cycles(1);
            evtCmd <= 8'h03;
            cycles(1);
            evtCmd <= 8'h02;
        end
        cycles(2);
        evtCmd <= 8'h00;
        cycles(2);
        rd(OFF_CNT);
        chk_reg(rdVal, 32'h3);
        report_and_stop;
    end
endmodule

// ===== tpw_evt_model.sv
// Far-side model: event channels, external count input and port levels.
// Assumes the bench commands event levels on ref_clk; all outputs synchronous.
`timescale 1ns/1ps
module tpw_evt_model
    import tpw_pkg::*;
#(
    parameter logic [7:0] PORT_LEVELS = 8'hA5
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] evtCmd,
    output logic [7:0] evtIn,
    output logic extIn,
    output logic [7:0] portVal
);
    // ----------------------------------------
    // Event routing and slow external input
    // ----------------------------------------
    logic [7:0] evtReg;
    logic [2:0] divReg;
    // Event channels arrive one cycle late, as through a routing network
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            evtReg <= 8'h00;
            divReg <= 3'h0;
        end
        else
        begin
            evtReg <= evtCmd;
            divReg <= divReg + 3'h1;
        end
    end
    assign evtIn = evtReg;
    assign extIn = divReg[2];
    assign portVal = PORT_LEVELS;
endmodule

// ===== tpw_pkg.sv
// Constants shared by the timer with dead-time block.
// Assumes a 32-bit classic Wishbone bus with byte addresses.
package tpw_pkg;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_FLAG = 8'h04;
    localparam logic [7:0] OFF_PER = 8'h08;
    localparam logic [7:0] OFF_CNT = 8'h0C;
    localparam logic [7:0] OFF_CC0 = 8'h10;
    localparam logic [7:0] CC_STEP = 8'h04;
    localparam logic [7:0] OFF_DT = 8'h20;
    localparam logic [7:0] OFF_PAT = 8'h24;
    localparam logic [7:0] OFF_FLT = 8'h28;
    localparam logic [7:0] OFF_CAP32 = 8'h2C;
    // ----------------------------------------
    // Control fields
    // ----------------------------------------
    localparam int CT_EN = 0;
    localparam int CT_PS = 1;
    localparam int CT_WM = 4;
    localparam int CT_SRC = 6;
    localparam int CT_DIRE = 8;
    localparam int CT_CAPE = 9;
    localparam int CT_BOTH = 13;
    localparam int CT_RST = 14;
    localparam int CT_HRE = 15;
    localparam int CT_HRS = 16;
    localparam int CT_AWU = 17;
    localparam int CT_PAT = 18;
    localparam int CT_CSEL = 19;
    localparam int CT_DSEL = 22;
    localparam int CT_CAS = 25;
    // ----------------------------------------
    // Other fields, modes, resets, timing
    // ----------------------------------------
    localparam int FL_OVF = 0;
    localparam int FL_ERR = 1;
    localparam int FL_CC = 2;
    localparam int FLT_ACK = 8;
    localparam int PAT_INV = 8;
    localparam logic [1:0] WM_NORM = 2'h0;
    localparam logic [1:0] WM_FREQ = 2'h1;
    localparam logic [1:0] WM_SS = 2'h2;
    localparam logic [1:0] WM_DS = 2'h3;
    localparam logic [1:0] SRC_CLK = 2'h0;
    localparam logic [1:0] SRC_EVT = 2'h1;
    localparam logic [1:0] SRC_EXT = 2'h2;
    localparam logic [31:0] CTRL_RST = 32'h0;
    localparam logic [15:0] PER_RST = 16'hFFFF;
    localparam logic [15:0] DT_RST = 16'h0;
    localparam logic [15:0] PAT_RST = 16'h0;
    localparam logic [1:0] HR_LAST = 2'h3;
    localparam int NC_LEN = 4;
endpackage

// ===== tpw_timer.sv
// 16-bit timer with capture, PWM, resolution extender, dead time,
// pattern override and fault latch. Assumes ref_clk is the fast
// peripheral clock (four times the CPU clock) and events are synchronous.
// Summary of operation
// - 16-bit counter, clock, event or external source
// - Type one four channels, type two two
// - Programmable prescaler on counter clock
// - Period and compare buffered, loaded at update
// - Single slope, dual slope, frequency waveforms
// - Event capture through noise canceller
// - Cascaded capture yields 32-bit value
// - Event input controls count direction
// - Overflow, error, per-channel flags and events
// - DMA request on timer events
// - Extender counts on fast clock, four times
// - Extender works with all waveforms and dead time
// - Extender selectable within timer pair
// - Type one splits outputs into pairs
// - Low side plain, high side inverted, dead time
// - Buffered 8-bit dead times per edge, shared by channels
// - Override selected pins, optional pin inversion
// - Pattern bypasses dead time, drives channel A
// - Masked events trigger fault, outputs off
`timescale 1ns/1ps
module tpw_timer
    import tpw_pkg::*;
#(
    parameter bit TYPE_ONE = 1'b1,
    parameter bit PAIR_IDX = 1'b0
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [7:0] evtIn,
    input wire logic extIn,
    input wire logic [15:0] cascadeCnt,
    input wire logic [7:0] portVal,
    output logic [7:0] pinOut,
    output logic [3:0] waveOut,
    output logic evtOvf,
    output logic evtErr,
    output logic [3:0] evtCc,
    output logic dmaReq,
    output logic irqOut
);
    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    function automatic logic [31:0] selMask(input logic [3:0] s);
        logic [31:0] m;
        m = 32'h0;
        for (int i = 0; i < 4; i++)
        begin
            if (s[i])
                m[8*i+:8] = 8'hFF;
        end
        return m;
    endfunction

    logic [31:0] ctrlReg, rdData;
    logic [5:0] flagReg, flagNext;
    logic [15:0] perBufReg, perActReg, cntReg, cntNext;
    logic [15:0] dtBufReg, dtActReg, patBufReg, patActReg, capHiReg;
    logic [7:0] fltMaskReg, evPrevReg, preReg, pinNext;
    logic [1:0] divReg;
    logic dnReg, dnNext, wrap, faultReg, extPrevReg;
    wire [15:0] ccAct [0:3];
    wire [3:0] capEv, match, waveVec, lsVec, hsVec;

    wire busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire busWr = busReq & wb_we_i;
    wire [31:0] bm = selMask(wb_sel_i);
    wire [31:0] wd = wb_dat_i & bm;
    wire hCtrl = busWr && wb_adr_i == OFF_CTRL;
    wire hFlag = busWr && wb_adr_i == OFF_FLAG;
    wire hPer = busWr && wb_adr_i == OFF_PER;
    wire hCnt = busWr && wb_adr_i == OFF_CNT;
    wire hDt = busWr && wb_adr_i == OFF_DT;
    wire hPat = busWr && wb_adr_i == OFF_PAT;
    wire hFlt = busWr && wb_adr_i == OFF_FLT;
    wire isCc = wb_adr_i[7:4] == OFF_CC0[7:4];
    wire [1:0] ccIdx = wb_adr_i[3:2];

    always_comb
    begin
        case (wb_adr_i)
            OFF_CTRL: rdData = ctrlReg;
            OFF_FLAG: rdData = {26'h0, flagReg};
            OFF_PER: rdData = {16'h0, perBufReg};
            OFF_CNT: rdData = {16'h0, cntReg};
            OFF_DT: rdData = {16'h0, dtBufReg};
            OFF_PAT: rdData = {16'h0, patBufReg};
            OFF_FLT: rdData = {23'h0, faultReg, fltMaskReg};
            OFF_CAP32: rdData = {16'h0, capHiReg};
            default: rdData = isCc ? {16'h0, ccAct[ccIdx]} : 32'h0;
        endcase
    end

    // ----------------------------------------
    // Clock selection and prescaler
    // ----------------------------------------
    wire en = ctrlReg[CT_EN];
    wire hrOn = ctrlReg[CT_HRE] && ctrlReg[CT_HRS] == PAIR_IDX;
    // Without the extender only every fourth fast edge is a CPU tick
    wire baseTick = hrOn || divReg == HR_LAST;
    wire [2:0] psSel = ctrlReg[CT_PS+:3];
    wire [7:0] psMask = ~(8'hFF << psSel);
    wire preTick = baseTick && (preReg & psMask) == psMask;
    wire [7:0] evRise = evtIn & ~evPrevReg;
    wire [1:0] srcSel = ctrlReg[CT_SRC+:2];
    wire [2:0] cSel = ctrlReg[CT_CSEL+:3];
    wire [2:0] dSel = ctrlReg[CT_DSEL+:3];
    wire extRise = extIn & ~extPrevReg;
    wire tick = en && (srcSel == SRC_CLK ? preTick :
        srcSel == SRC_EVT ? evRise[cSel] : srcSel == SRC_EXT && extRise);

    // ----------------------------------------
    // Counter
    // ----------------------------------------
    wire [1:0] wm = ctrlReg[CT_WM+:2];
    wire dsMode = wm == WM_DS;
    wire [15:0] top = wm == WM_FREQ ? ccAct[0] : perActReg;
    wire downMode = ctrlReg[CT_DIRE] && evtIn[dSel] && !dsMode;
    wire restart = ctrlReg[CT_RST] && capEv[0];
    wire upd = wrap || !en;

    always_comb
    begin
        cntNext = cntReg;
        dnNext = dnReg;
        wrap = 1'b0;
        if (tick)
        begin
            if (dsMode && !dnReg)
            begin
                if (cntReg >= top)
                begin
                    dnNext = 1'b1;
                    cntNext = cntReg - 16'h1;
                end
                else
                    cntNext = cntReg + 16'h1;
            end
            else if (dsMode || downMode)
            begin
                if (cntReg == 16'h0)
                begin
                    wrap = 1'b1;
                    dnNext = 1'b0;
                    cntNext = dsMode ? 16'h1 : top;
                end
                else
                    cntNext = cntReg - 16'h1;
            end
            else if (cntReg >= top)
            begin
                wrap = 1'b1;
                cntNext = 16'h0;
            end
            else
                cntNext = cntReg + 16'h1;
        end
        if (restart)
            cntNext = 16'h0;
        if (hCnt)
            cntNext = (cntReg & ~bm[15:0]) | wd[15:0];
    end

    // ----------------------------------------
    // Flags and fault
    // ----------------------------------------
    wire [3:0] ccSet = match | capEv;
    wire errSet = |(capEv & flagReg[FL_CC+:4]);
    wire [5:0] flagClr = hFlag ? wd[5:0] : 6'h0;
    wire fltAck = hFlt && wd[FLT_ACK];
    wire fltHit = |(evtIn & fltMaskReg);
    wire faultNext = TYPE_ONE && (fltHit || (faultReg && !fltAck));
    wire awuOn = TYPE_ONE && ctrlReg[CT_AWU];
    wire patOn = TYPE_ONE && ctrlReg[CT_PAT];
    assign flagNext = (flagReg & ~flagClr) | {ccSet, errSet, wrap};

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrlReg <= CTRL_RST;
            flagReg <= 6'h0;
            perBufReg <= PER_RST;
            perActReg <= PER_RST;
            dtBufReg <= DT_RST;
            dtActReg <= DT_RST;
            patBufReg <= PAT_RST;
            patActReg <= PAT_RST;
            fltMaskReg <= 8'h0;
            faultReg <= 1'b0;
            capHiReg <= 16'h0;
            cntReg <= 16'h0;
            dnReg <= 1'b0;
            divReg <= 2'h0;
            preReg <= 8'h0;
            evPrevReg <= 8'h0;
            extPrevReg <= 1'b0;
        end
        else
        begin
            if (hCtrl)
                ctrlReg <= (ctrlReg & ~bm) | wd;
            if (hPer)
                perBufReg <= (perBufReg & ~bm[15:0]) | wd[15:0];
            if (hDt)
                dtBufReg <= (dtBufReg & ~bm[15:0]) | wd[15:0];
            if (hPat)
                patBufReg <= (patBufReg & ~bm[15:0]) | wd[15:0];
            if (hFlt)
                fltMaskReg <= (fltMaskReg & ~bm[7:0]) | wd[7:0];
            if (upd)
            begin
                perActReg <= perBufReg;
                dtActReg <= dtBufReg;
                patActReg <= patBufReg;
            end
            if (capEv[0] && ctrlReg[CT_CAS])
                capHiReg <= cascadeCnt;
            flagReg <= flagNext;
            faultReg <= faultNext;
            cntReg <= cntNext;
            dnReg <= dnNext;
            divReg <= divReg + 2'h1;
            if (baseTick)
                preReg <= preReg + 8'h1;
            evPrevReg <= evtIn;
            extPrevReg <= extIn;
        end
    end

    // ----------------------------------------
    // Channels
    // ----------------------------------------
    for (genvar k = 0; k < 4; k++)
    begin : gCh
        localparam bit ON = TYPE_ONE || k < 2;
        logic [15:0] bufReg, actReg;
        logic [NC_LEN-1:0] shReg;
        logic [7:0] dtReg;
        logic filtReg, waveReg, prevReg, lsReg, hsReg;
        wire capMode = ON && ctrlReg[CT_CAPE+k];
        wire [2:0] inSel = cSel + 3'(k);
        // Level only changes after NC_LEN equal samples
        wire filtNext = &shReg ? 1'b1 : ~|shReg ? 1'b0 : filtReg;
        wire capHit = capMode && filtNext != filtReg && (filtNext || ctrlReg[CT_BOTH]);
        wire hitCc = ON && busWr && wb_adr_i == 8'(OFF_CC0 + CC_STEP * 8'(k));
        wire ramp = wm == WM_SS || wm == WM_DS;
        wire waveNext = !ON || capMode ? 1'b0 : ramp ? cntReg < actReg :
            wm == WM_FREQ && k == 0 ? waveReg ^ wrap : 1'b0;

        always_ff @(posedge ref_clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                bufReg <= 16'h0;
                actReg <= 16'h0;
                shReg <= '0;
                dtReg <= 8'h0;
                filtReg <= 1'b0;
                waveReg <= 1'b0;
                prevReg <= 1'b0;
                lsReg <= 1'b0;
                hsReg <= 1'b0;
            end
            else
            begin
                shReg <= {shReg[NC_LEN-2:0], evtIn[inSel]};
                filtReg <= filtNext;
                if (hitCc)
                    bufReg <= (bufReg & ~bm[15:0]) | wd[15:0];
                if (capHit)
                    actReg <= cntReg;
                else if (!capMode && upd)
                    actReg <= bufReg;
                waveReg <= waveNext;
                prevReg <= waveReg;
                // Both sides off while the dead time runs
                if (waveReg != prevReg)
                begin
                    lsReg <= 1'b0;
                    hsReg <= 1'b0;
                    dtReg <= waveReg ? dtActReg[7:0] : dtActReg[15:8];
                end
                else if (dtReg != 8'h0)
                    dtReg <= dtReg - 8'h1;
                else
                begin
                    lsReg <= prevReg;
                    hsReg <= ~prevReg;
                end
            end
        end
        assign ccAct[k] = actReg;
        assign capEv[k] = capHit;
        assign match[k] = ON && tick && !capMode && cntReg == actReg;
        assign waveVec[k] = waveReg;
        assign lsVec[k] = lsReg;
        assign hsVec[k] = hsReg;
    end

    // ----------------------------------------
    // Pin override
    // ----------------------------------------
    for (genvar i = 0; i < 8; i++)
    begin : gPin
        // Pattern mode skips dead time and fans out channel A
        wire drv = patOn ? waveVec[0] : i % 2 == 1 ? hsVec[i/2] : lsVec[i/2];
        wire own = (awuOn || patOn) && patActReg[i];
        assign pinNext[i] = (own ? drv & ~faultReg : portVal[i]) ^ patActReg[PAT_INV+i];
    end

    assign waveOut = waveVec;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
            pinOut <= 8'h0;
            evtOvf <= 1'b0;
            evtErr <= 1'b0;
            evtCc <= 4'h0;
            dmaReq <= 1'b0;
            irqOut <= 1'b0;
        end
        else
        begin
            wb_ack_o <= busReq;
            wb_dat_o <= busReq ? rdData : 32'h0;
            pinOut <= pinNext;
            evtOvf <= wrap;
            evtErr <= errSet;
            evtCc <= ccSet;
            dmaReq <= wrap || |ccSet;
            irqOut <= |flagNext;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    AST_CNT_WRAP: assert property (
        wrap && !dsMode && !downMode && !restart && !hCnt |=> cntReg == 16'h0)
        else $error("counter did not return to zero");
    AST_PER_LOAD: assert property (
        $changed(perActReg) |-> $past(upd))
        else $error("period changed outside update");
    AST_SS_WAVE: assert property (
        wm == WM_SS && !ctrlReg[CT_CAPE] && $stable(wm) |=> waveVec[0] == $past(cntReg < ccAct[0]))
        else $error("single slope output wrong");
    AST_OVF_FLAG: assert property (
        wrap |=> flagReg[FL_OVF] && evtOvf && dmaReq)
        else $error("overflow not flagged");
    AST_DT_GAP: assert property (
        !(lsVec[0] && hsVec[0]))
        else $error("both sides on together");
    AST_FLT_SET: assert property (
        TYPE_ONE && fltHit |=> faultReg)
        else $error("fault not latched");
    AST_FLT_HOLD: assert property (
        faultReg && !fltAck |=> faultReg)
        else $error("fault released without acknowledge");
    AST_FLT_OFF: assert property (
        faultReg && (awuOn || patOn) && patActReg[0] |=> pinOut[0] == $past(patActReg[PAT_INV]))
        else $error("faulted pin still driven");
    AST_WB_ACK: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");
endmodule
